// file: aos_pkg.sv
// Constants and types shared by the angle output stage
`default_nettype none
package aos_pkg;
  localparam logic [1:0] STAGE_FULL = 2'h0;
  localparam logic [1:0] STAGE_REDUCED = 2'h1;
  localparam logic [1:0] STAGE_PWM = 2'h2;
  // Maximum angle in 12-bit steps; zero means the full 360 degree turn
  localparam logic [11:0] SPAN_FULL = 12'h000;
  localparam logic [11:0] SPAN_MIN = 12'h0CD;
  localparam logic [12:0] STEPS_FULL = 13'h1000;
  localparam logic [11:0] WRAP_BAND = 12'h00A;
  localparam logic [11:0] WRAP_MID = 12'h800;
  localparam logic [11:0] CODE_MAX = 12'hFFF;
  localparam logic [23:0] DIVIDEND_SCALE = 24'h000FFF;
  localparam logic [4:0] DIV_STEPS = 5'h18;
  localparam logic [11:0] RED_BASE = 12'h19A;
  localparam logic [11:0] RED_SPAN = 12'hCCC;
  localparam logic [12:0] PWM_HIGH = 13'h0080;
  localparam logic [12:0] PWM_FRAME_LAST = 13'h10FE;
  // Clocks per PWM period, indexed by pwm_freq_select
  localparam logic [3:0][9:0] PWM_DIV = {10'h032, 10'h064, 10'h0C8, 10'h190};
  // Slow filter shift, indexed by slow_filter_select; larger shift is slower
  localparam logic [3:0][2:0] SLOW_SHIFT = {3'h1, 3'h2, 3'h3, 3'h4};
  // Fast filter enter and leave thresholds in LSB, indexed by code
  localparam logic [7:0][4:0] FAST_ENTER = {5'h0A, 5'h18, 5'h15, 5'h12, 5'h09, 5'h07, 5'h06, 5'h00};
  localparam logic [7:0][4:0] FAST_LEAVE = {5'h04, 5'h02, 5'h02, 5'h02, 5'h01, 5'h01, 5'h01, 5'h00};
  localparam logic [11:0] WDOG_BAND = 12'h004;
  localparam logic [15:0] WDOG_MS = 16'hEA60;
  // Polling period in ms for each power state
  localparam logic [3:0][7:0] POLL_MS = {8'h64, 8'h14, 8'h05, 8'h01};
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MS_PS = 1000000000;
  typedef enum logic [3:0] {
    PS_NOMINAL = 4'h1,
    PS_LOW_ONE = 4'h2,
    PS_LOW_TWO = 4'h4,
    PS_LOW_POWER_LEVEL_THREE = 4'h8
  } aos_pwr_type;
endpackage
`default_nettype wire

// file: aos_top.sv
// Angle output stage: filter, hysteresis, span mapping, DAC/PWM drive, power modes
// Functional notes
// RULE_01 - Select field picks full analog, reduced, PWM
// RULE_02 - PWM mode powers the converter down
// RULE_03 - Current angle readable at any time
// RULE_04 - Analog mode drives 12-bit ratiometric code
// RULE_05 - Span 18 to 360 degrees, default 360
// RULE_06 - Full turn uses 10-LSB wrap hysteresis
// RULE_07 - Discontinuities sit half the gap outside span
// RULE_08 - Reduced span lowers step count proportionally
// RULE_09 - Select 10 drives angle-proportional PWM
// RULE_10 - Frame 4351 periods: 128 high, 4095, 128 low
// RULE_11 - Zero angle 128 high, maximum 4223 high
// RULE_12 - Frequency select sets PWM clock rate
// RULE_13 - Slow filter select sets step delay
// RULE_14 - Fast filter only above threshold change
// RULE_15 - Threshold code table, 000 slow only
// RULE_16 - Fast filter settles within two samples
// RULE_17 - Polarity input chooses counting direction
// RULE_18 - Output hysteresis of 1 to 3 LSB
// RULE_19 - Weak field drives output low, clears flag
// RULE_20 - State machine manages three low-power modes
// RULE_21 - Watchdog: still angle one minute, deepest mode
// RULE_22 - Reduced range maps linearly 10% to 90%
`timescale 1ns/1ps
`default_nettype none
module aos_top #(
  parameter int MS_CYCLES = aos_pkg::MS_PS / aos_pkg::CLK_PERIOD_PS
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [11:0] RAW_ANGLE,
  input wire logic RAW_VALID,
  input wire logic DIR_PIN,
  input wire logic FIELD_OK,
  input wire logic [11:0] ZERO_POSITION,
  input wire logic [11:0] MAX_ANGLE,
  input wire logic [1:0] OUTPUT_STAGE_SELECT,
  input wire logic [1:0] PWM_FREQ_SELECT,
  input wire logic [1:0] SLOW_FILTER_SELECT,
  input wire logic [2:0] FAST_FILTER_THRESHOLD,
  input wire logic [1:0] OUTPUT_HYSTERESIS_SELECT,
  input wire logic [1:0] POWER_MODE_SELECT,
  input wire logic WATCHDOG_ENABLE_BIT,
  output logic [11:0] ANGLE,
  output logic [11:0] DAC_CODE,
  output logic DAC_POWER_DOWN,
  output logic PWM_OUT,
  output logic MAGNET_PRESENT_FLAG,
  output logic [3:0] POWER_STATE,
  output logic SAMPLE_REQUEST
);
  // Pin synchronisers
  logic dir_s1_reg, dir_s2_reg, fld_s1_reg, fld_s2_reg;
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      dir_s1_reg <= 1'b0;
      dir_s2_reg <= 1'b0;
      fld_s1_reg <= 1'b0;
      fld_s2_reg <= 1'b0;
    end else begin
      dir_s1_reg <= DIR_PIN;
      dir_s2_reg <= dir_s1_reg;
      fld_s1_reg <= FIELD_OK;
      fld_s2_reg <= fld_s1_reg;
    end
  end

  // Filter and hysteresis, one update per sample
  logic [15:0] filt_reg, filt_next;
  logic fast_reg, fast_next;
  logic [11:0] hold_reg, hold_next;
  logic go_reg, go_next;
  logic [11:0] pos, hv, hmag;
  logic [15:0] diff;
  logic [11:0] mag;
  always_comb begin
    pos = (dir_s2_reg ? (12'h000 - RAW_ANGLE) : RAW_ANGLE) - ZERO_POSITION; // see RULE_17
    diff = {pos, 4'h0} - filt_reg;
    mag = diff[15] ? 12'((16'h0000 - diff) >> 4) : diff[15:4];
    filt_next = filt_reg;
    fast_next = fast_reg;
    hold_next = hold_reg;
    go_next = RAW_VALID;
    hv = hold_reg;
    hmag = 12'h000;
    if (RAW_VALID) begin
      if (FAST_FILTER_THRESHOLD == 3'h0) begin
        fast_next = 1'b0; // see RULE_15
      end else if (mag > 12'(aos_pkg::FAST_ENTER[FAST_FILTER_THRESHOLD])) begin
        fast_next = 1'b1; // see RULE_14
      end else if (mag <= 12'(aos_pkg::FAST_LEAVE[FAST_FILTER_THRESHOLD])) begin
        fast_next = 1'b0; // see RULE_15
      end
      // Fast mode jumps to the new sample, so it settles well inside two samples
      if (fast_next) begin
        filt_next = {pos, 4'h0}; // see RULE_16
      end else begin
        filt_next = filt_reg + 16'($signed(diff) >>> aos_pkg::SLOW_SHIFT[SLOW_FILTER_SELECT]); // see RULE_13
      end
      hv = filt_next[15:4];
      hmag = (hv - hold_reg);
      hmag = hmag[11] ? (12'h000 - hmag) : hmag;
      if (hmag > 12'(OUTPUT_HYSTERESIS_SELECT)) begin
        hold_next = hv; // see RULE_18
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      filt_reg <= 16'h0000;
      fast_reg <= 1'b0;
      hold_reg <= 12'h000;
      go_reg <= 1'b0;
    end else begin
      filt_reg <= filt_next;
      fast_reg <= fast_next;
      hold_reg <= hold_next;
      go_reg <= go_next;
    end
  end

  // Span mapping; a serial divider keeps area small at the cost of 24 cycles latency
  logic [11:0] span;
  logic [12:0] lambda, edge_hi;
  logic [23:0] dvd_reg, dvd_next;
  logic [12:0] rem_reg, rem_next, trial;
  logic [4:0] div_cnt_reg, div_cnt_next;
  logic [11:0] angle_reg, angle_next;
  always_comb begin
    span = (MAX_ANGLE == aos_pkg::SPAN_FULL || MAX_ANGLE >= aos_pkg::SPAN_MIN) ? MAX_ANGLE : aos_pkg::SPAN_MIN; // see RULE_05
    lambda = (aos_pkg::STEPS_FULL - {1'b0, span}) >> 1;
    edge_hi = {1'b0, span} + lambda;
    dvd_next = dvd_reg;
    rem_next = rem_reg;
    div_cnt_next = div_cnt_reg;
    angle_next = angle_reg;
    trial = {rem_reg[11:0], dvd_reg[23]};
    if (go_reg) begin
      if (span == aos_pkg::SPAN_FULL) begin
        // Keep the old side of the wrap until the angle moves 10 LSB past it
        if (angle_reg >= aos_pkg::WRAP_MID && hold_reg < aos_pkg::WRAP_BAND) begin
          angle_next = aos_pkg::CODE_MAX; // see RULE_06
        end else if (angle_reg < aos_pkg::WRAP_MID && hold_reg > aos_pkg::CODE_MAX - aos_pkg::WRAP_BAND) begin
          angle_next = 12'h000; // see RULE_06
        end else begin
          angle_next = hold_reg;
        end
      end else if (hold_reg < span) begin
        dvd_next = {12'h000, hold_reg} * aos_pkg::DIVIDEND_SCALE; // see RULE_08
        rem_next = 13'h0000;
        div_cnt_next = aos_pkg::DIV_STEPS;
      end else if ({1'b0, hold_reg} < edge_hi) begin
        angle_next = aos_pkg::CODE_MAX; // see RULE_07
      end else begin
        angle_next = 12'h000; // see RULE_07
      end
    end else if (div_cnt_reg != 5'h00) begin
      if (trial >= {1'b0, span}) begin
        rem_next = trial - {1'b0, span};
        dvd_next = {dvd_reg[22:0], 1'b1};
      end else begin
        rem_next = trial;
        dvd_next = {dvd_reg[22:0], 1'b0};
      end
      div_cnt_next = div_cnt_reg - 5'h01;
      if (div_cnt_reg == 5'h01) begin
        angle_next = dvd_next[11:0]; // see RULE_08
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      dvd_reg <= 24'h000000;
      rem_reg <= 13'h0000;
      div_cnt_reg <= 5'h00;
      angle_reg <= 12'h000;
    end else begin
      dvd_reg <= dvd_next;
      rem_reg <= rem_next;
      div_cnt_reg <= div_cnt_next;
      angle_reg <= angle_next;
    end
  end

  // Analog and status outputs
  logic [11:0] dac_next;
  logic [23:0] red_prod;
  logic dac_pd_next, present_next;
  always_comb begin
    present_next = fld_s2_reg;
    red_prod = {12'h000, angle_reg} * {12'h000, aos_pkg::RED_SPAN};
    dac_pd_next = (OUTPUT_STAGE_SELECT == aos_pkg::STAGE_PWM); // see RULE_02
    if (!present_next || dac_pd_next) begin
      dac_next = 12'h000; // see RULE_19
    end else if (OUTPUT_STAGE_SELECT == aos_pkg::STAGE_REDUCED) begin
      dac_next = aos_pkg::RED_BASE + red_prod[23:12]; // see RULE_22
    end else begin
      dac_next = angle_reg; // see RULE_04
    end
  end
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      DAC_CODE <= 12'h000;
      DAC_POWER_DOWN <= 1'b0;
      MAGNET_PRESENT_FLAG <= 1'b0;
      ANGLE <= 12'h000;
    end else begin
      DAC_CODE <= dac_next; // see RULE_01
      DAC_POWER_DOWN <= dac_pd_next;
      MAGNET_PRESENT_FLAG <= present_next; // see RULE_19
      ANGLE <= angle_reg; // see RULE_03
    end
  end

  // PWM frame generator
  logic [9:0] pdiv_reg, pdiv_next;
  logic [12:0] frame_reg, frame_next;
  logic [11:0] duty_reg, duty_next;
  logic pwm_next;
  always_comb begin
    pdiv_next = pdiv_reg + 10'h001;
    frame_next = frame_reg;
    duty_next = duty_reg;
    if (pdiv_reg >= aos_pkg::PWM_DIV[PWM_FREQ_SELECT] - 10'h001) begin
      pdiv_next = 10'h000; // see RULE_12
      if (frame_reg == aos_pkg::PWM_FRAME_LAST) begin
        frame_next = 13'h0000; // see RULE_10
        duty_next = angle_reg;
      end else begin
        frame_next = frame_reg + 13'h0001;
      end
    end
    // Duty latched once per frame so a frame never carries two angles
    pwm_next = fld_s2_reg && (OUTPUT_STAGE_SELECT == aos_pkg::STAGE_PWM) &&
               (frame_reg < aos_pkg::PWM_HIGH + {1'b0, duty_reg}); // see RULE_09 see RULE_11 see RULE_19
  end
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      pdiv_reg <= 10'h000;
      frame_reg <= 13'h0000;
      duty_reg <= 12'h000;
      PWM_OUT <= 1'b0;
    end else begin
      pdiv_reg <= pdiv_next;
      frame_reg <= frame_next;
      duty_reg <= duty_next;
      PWM_OUT <= pwm_next;
    end
  end

  // Power modes, polling and watchdog
  aos_pkg::aos_pwr_type pwr_reg, pwr_next;
  logic [17:0] ms_cnt_reg, ms_cnt_next;
  logic [15:0] wdog_cnt_reg, wdog_cnt_next;
  logic [11:0] wdog_ref_reg, wdog_ref_next, wdog_dev;
  logic [7:0] poll_reg, poll_next;
  logic ms_tick, sample_next;
  always_comb begin
    ms_tick = (ms_cnt_reg >= 18'(MS_CYCLES - 1));
    ms_cnt_next = ms_tick ? 18'h00000 : ms_cnt_reg + 18'h00001;
    wdog_dev = angle_reg - wdog_ref_reg;
    wdog_dev = wdog_dev[11] ? (12'h000 - wdog_dev) : wdog_dev;
    wdog_ref_next = wdog_ref_reg;
    wdog_cnt_next = wdog_cnt_reg;
    if (!WATCHDOG_ENABLE_BIT || wdog_dev > aos_pkg::WDOG_BAND) begin
      wdog_ref_next = angle_reg;
      wdog_cnt_next = 16'h0000;
    end else if (ms_tick && wdog_cnt_reg != aos_pkg::WDOG_MS) begin
      wdog_cnt_next = wdog_cnt_reg + 16'h0001; // see RULE_21
    end
    if (WATCHDOG_ENABLE_BIT && wdog_cnt_reg == aos_pkg::WDOG_MS) begin
      pwr_next = aos_pkg::PS_LOW_POWER_LEVEL_THREE; // see RULE_21
    end else begin
      case (POWER_MODE_SELECT) // see RULE_20
        2'h1: pwr_next = aos_pkg::PS_LOW_ONE;
        2'h2: pwr_next = aos_pkg::PS_LOW_TWO;
        2'h3: pwr_next = aos_pkg::PS_LOW_POWER_LEVEL_THREE;
        default: pwr_next = aos_pkg::PS_NOMINAL;
      endcase
    end
    poll_next = poll_reg;
    sample_next = 1'b0;
    if (ms_tick) begin
      poll_next = poll_reg + 8'h01;
      case (pwr_reg)
        aos_pkg::PS_LOW_ONE: sample_next = (poll_next >= aos_pkg::POLL_MS[1]);
        aos_pkg::PS_LOW_TWO: sample_next = (poll_next >= aos_pkg::POLL_MS[2]);
        aos_pkg::PS_LOW_POWER_LEVEL_THREE: sample_next = (poll_next >= aos_pkg::POLL_MS[3]);
        default: sample_next = (poll_next >= aos_pkg::POLL_MS[0]);
      endcase
      if (sample_next) begin
        poll_next = 8'h00; // see RULE_20
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      pwr_reg <= aos_pkg::PS_NOMINAL;
      ms_cnt_reg <= 18'h00000;
      wdog_cnt_reg <= 16'h0000;
      wdog_ref_reg <= 12'h000;
      poll_reg <= 8'h00;
      POWER_STATE <= 4'h1;
      SAMPLE_REQUEST <= 1'b0;
    end else begin
      pwr_reg <= pwr_next;
      ms_cnt_reg <= ms_cnt_next;
      wdog_cnt_reg <= wdog_cnt_next;
      wdog_ref_reg <= wdog_ref_next;
      poll_reg <= poll_next;
      POWER_STATE <= pwr_next;
      SAMPLE_REQUEST <= sample_next;
    end
  end
endmodule
`default_nettype wire

// file: aos_monitor.sv
// Port checks for the angle output stage
`timescale 1ns/1ps
`default_nettype none
module aos_monitor #(
  parameter int MS_CYCLES = 10
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic RAW_VALID,
  input wire logic FIELD_OK,
  input wire logic [1:0] OUTPUT_STAGE_SELECT,
  input wire logic [1:0] POWER_MODE_SELECT,
  input wire logic WATCHDOG_ENABLE_BIT,
  input wire logic [11:0] ANGLE,
  input wire logic [11:0] DAC_CODE,
  input wire logic DAC_POWER_DOWN,
  input wire logic PWM_OUT,
  input wire logic MAGNET_PRESENT_FLAG,
  input wire logic [3:0] POWER_STATE,
  input wire logic SAMPLE_REQUEST
);
  // Outputs settle a few edges after reset, so checks wait for that
  logic [2:0] live_reg;
  logic [5:0] idle_reg;
  always_ff @(posedge CLK) begin
    live_reg <= RESETN ? {live_reg[1:0], 1'b1} : 3'h0;
    idle_reg <= (!RESETN || RAW_VALID) ? 6'h00 : idle_reg + {5'h00, idle_reg != 6'h3F};
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN || !live_reg[2]);
  AST_PD: assert property (DAC_POWER_DOWN == ($past(OUTPUT_STAGE_SELECT) == 2'h2))
    else $error("power down wrong");
  AST_PWM_QUIET: assert property (OUTPUT_STAGE_SELECT != 2'h2 |=> !PWM_OUT)
    else $error("pwm pin active outside pwm");
  AST_DAC_OFF: assert property ((OUTPUT_STAGE_SELECT == 2'h2) [*2] |=> DAC_CODE == 12'h000)
    else $error("dac code in pwm mode");
  AST_NO_MAG: assert property (!MAGNET_PRESENT_FLAG [*2] |-> DAC_CODE == 12'h000 && !PWM_OUT)
    else $error("output not low without magnet");
  AST_FLAG: assert property ($stable(FIELD_OK) [*4] |=> MAGNET_PRESENT_FLAG == $past(FIELD_OK))
    else $error("magnet flag wrong");
  AST_STATE: assert property ($stable(POWER_MODE_SELECT) && !WATCHDOG_ENABLE_BIT |=>
    POWER_STATE == (4'h1 << $past(POWER_MODE_SELECT)))
    else $error("power state wrong");
  AST_ONEHOT: assert property ($onehot(POWER_STATE))
    else $error("power state not one-hot");
  AST_POLL: assert property (SAMPLE_REQUEST |=> !SAMPLE_REQUEST)
    else $error("poll pulse too long");
  AST_STILL: assert property (idle_reg > 6'h1E |-> $stable(ANGLE))
    else $error("angle moved without sample");
endmodule
bind aos_top aos_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (.*);
`default_nettype wire

// file: aos_pwm_rx.sv
// Output pin receiver: measures high pulse length
`timescale 1ns/1ps
`default_nettype none
module aos_pwm_rx (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output int hi_len,
  output int n_pulse
);
  int run;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run <= 0;
      hi_len <= 0;
      n_pulse <= 0;
    end else if (pin) begin
      run <= run + 1;
    end else if (run != 0) begin
      hi_len <= run;
      n_pulse <= n_pulse + 1;
      run <= 0;
    end
  end
endmodule
`default_nettype wire

// file: angle_output_stage_tb_top.sv
// Self-checking bench for the angle output stage
`timescale 1ns/1ps
`default_nettype none
module angle_output_stage_tb_top;
  logic clk = 0, rstn = 0, vld = 0, dir = 0, fok = 1, wde = 0;
  logic [11:0] raw = 0, zpos = 0, mang = 0;
  logic [1:0] stage_sel = 0, freq_sel = 0, slow_sel = 0, band_sel = 0, mode_sel = 0;
  logic [2:0] thr_sel = 3'h1;
  logic [11:0] ang, dac;
  logic pd, pwm, mag, req;
  logic [3:0] pst;
  int error_cnt = 0, comparisons = 0, hi, np, ma = 0, mh = 0, n;
  int poll[4] = '{1, 5, 20, 100};
  // Slow-to-fast thresholds per code; code 0 never enters fast mode
  int enter_tab[8] = '{0, 6, 7, 9, 18, 21, 24, 10};
  aos_top #(.MS_CYCLES(10)) i_dut (.CLK(clk), .RESETN(rstn), .RAW_ANGLE(raw), .RAW_VALID(vld), .DIR_PIN(dir),
    .FIELD_OK(fok), .ZERO_POSITION(zpos), .MAX_ANGLE(mang), .OUTPUT_STAGE_SELECT(stage_sel),
    .PWM_FREQ_SELECT(freq_sel), .SLOW_FILTER_SELECT(slow_sel), .FAST_FILTER_THRESHOLD(thr_sel),
    .OUTPUT_HYSTERESIS_SELECT(band_sel), .POWER_MODE_SELECT(mode_sel), .WATCHDOG_ENABLE_BIT(wde), .ANGLE(ang),
    .DAC_CODE(dac), .DAC_POWER_DOWN(pd),
    .PWM_OUT(pwm), .MAGNET_PRESENT_FLAG(mag), .POWER_STATE(pst), .SAMPLE_REQUEST(req));
  aos_pwm_rx u_rx (.clk(clk), .rst_n(rstn), .pin(pwm), .hi_len(hi), .n_pulse(np));
  initial forever #2.5 clk = ~clk;
  task chk(input string nm, input logic [11:0] e, input logic [11:0] s);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  task chk_rng(input string nm, input int lo, input int up, input int s);
    comparisons++;
    if (s < lo || s > up) begin
      error_cnt++;
      $display("[FAIL] %s exp %0d..%0d got %0d", nm, lo, up, s);
    end
  endtask
  task give_verdict;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task rst;
    rstn = 0;
    repeat (5) @(negedge clk);
    rstn = 1;
    ma = 0;
    mh = 0;
  endtask
  function int hof(input logic [11:0] r);
    return ((dir ? 4096 - r : r) - zpos) & 4095;
  endfunction
  // Steps stay clear of the fast threshold band so the filter copies the sample
  task automatic step(input logic [11:0] r);
    int h, sp, m, d;
    // Distances are taken around the circle, as the filter and hysteresis see them
    d = (hof(r) - mh) & 4095;
    if (d > 2048) d = 4096 - d;
    if (d > band_sel && d <= enter_tab[thr_sel]) r = r + 12'h080;
    h = hof(r);
    d = (h - mh) & 4095;
    if (d > 2048) d = 4096 - d;
    if (d <= band_sel) h = mh;
    mh = h;
    // Let the synchronised direction pin settle before the first sample
    repeat (3) @(negedge clk);
    repeat (3) begin
      @(negedge clk);
      raw = r;
      vld = 1;
      @(negedge clk);
      vld = 0;
      repeat (30) @(negedge clk);
    end
    sp = mang == 0 ? 4096 : (mang < 12'h0CD ? 205 : mang);
    if (sp == 4096) m = (ma >= 2048 && h < 10) ? 4095 : (ma < 2048 && h > 4085) ? 0 : h;
    else m = h < sp ? h * 4095 / sp : h < sp + (4096 - sp) / 2 ? 4095 : 0;
    ma = m;
    chk("ANGLE", 12'(m), ang);
    chk("DAC_CODE", stage_sel == 1 ? 12'(410 + (m * 3276 >> 12)) : stage_sel == 2 ? 12'h000 : 12'(m), dac);
  endtask
  logic [11:0] wrap_tab[6] = '{12'h100, 12'hFFA, 12'h005, 12'h900, 12'h004, 12'h300};
  initial begin
    void'($urandom(43));
    rst;
    foreach (wrap_tab[i]) step(wrap_tab[i]);
    for (int i = 0; i < 16; i++) begin
      thr_sel = 3'(1 + i % 7);
      slow_sel = 2'($urandom);
      if (i == 4) zpos = 12'($urandom);
      if (i == 7) {dir, zpos} = 13'h1000;
      if (i == 10) {dir, stage_sel, mang} = 15'h0400;
      if (i == 10) stage_sel = 2'h1;
      if (i == 14) mang = 12'h010;
      step(12'($urandom));
    end
    {stage_sel, mang, band_sel} = 16'h0003;
    step(12'h600);
    step(12'h602);
    fok = 0;
    repeat (8) @(negedge clk);
    chk("FLAG", 12'h000, {11'h000, mag});
    chk("DAC_LOW", 12'h000, dac);
    fok = 1;
    stage_sel = 2'h2;
    step(12'h234);
    chk("PWR_DN", 12'h001, {11'h000, pd});
    for (int f = 3; f >= 2; f--) begin
      freq_sel = 2'(f);
      rst;
      n = 0;
      while (np == 0 && n < 20000) begin
        @(negedge clk);
        n++;
      end
      chk_rng("PWM_HIGH", 128 * (50 << (3 - f)) - 5, 128 * (50 << (3 - f)), hi);
    end
    stage_sel = 2'h0;
    for (int i = 0; i < 4; i++) begin
      mode_sel = 2'(i);
      repeat (2) begin
        n = 0;
        do begin
          @(negedge clk);
          n++;
        end while (!req && n < 1100);
      end
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (!req && n < 1100);
      chk("POLL", 12'(poll[i] * 10), 12'(n));
      chk("PSTATE", 12'(1 << i), {8'h00, pst});
    end
    give_verdict;
  end
  initial begin
    // About three times the expected run, still well below the cycle budget
    #400000;
    error_cnt++;
    give_verdict;
  end
endmodule
`default_nettype wire
